// ===== hw/pmt_defines.vh
// Constants for the program-memory table-read and in-application programming block.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef PMT_DEFINES_VH
`define PMT_DEFINES_VH
// ----------------------------------------------------------------
// Data-memory addresses of the flash access registers
// ----------------------------------------------------------------
`define PMT_BANK_ZERO 1'h0
`define PMT_BANK_ONE 1'h1
`define PMT_ADDR_CTRL_ZERO 8'h40
`define PMT_ADDR_CTRL_ONE 8'h41
`define PMT_ADDR_CTRL_TWO 8'h42
`define PMT_ADDR_FA_LOW 8'h43
`define PMT_ADDR_FA_HIGH 8'h44
`define PMT_ADDR_FD_BASE 8'h45
`define PMT_ADDR_FD_LAST 8'h4C
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PMT_C0_CONFIRM 7
`define PMT_C0_MODE_HI 6
`define PMT_C0_MODE_LO 4
`define PMT_C0_PROC_EN 3
`define PMT_C0_WRITE 2
`define PMT_C0_RDEN 1
`define PMT_C0_READ 0
`define PMT_MODE_WRITE 3'h0
`define PMT_MODE_ERASE 3'h1
`define PMT_MODE_READ 3'h3
`define PMT_MODE_UNLOCK 3'h6
`define PMT_CHIP_RESET_KEY 8'h55
`define PMT_KEY_D1L 8'h00
`define PMT_KEY_D1H 8'h04
`define PMT_KEY_D2L 8'h0D
`define PMT_KEY_D2H 8'h09
`define PMT_KEY_D3L 8'hC3
`define PMT_KEY_D3H 8'h40
// ----------------------------------------------------------------
// Timing and geometry
// ----------------------------------------------------------------
`define PMT_UNLOCK_WINDOW_US 300
`define PMT_LOW_SPEED_INTERNAL_OSCILLATOR_HZ 32000
`define PMT_RESET_VECTOR 15'h0000
`define PMT_BANK_PTR_LO 5
`define PMT_TABLE_CYCLES 2'h2
`endif

// ===== hw/pmt_sync2.v
// Two-flop synchroniser for one level arriving from outside the clock domain.
// Assumes a single clock; the first flop is read only by the second.
module pmt_sync2 (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire d,
  output reg q
);
  reg meta_q;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ===== hw/pmt_core.v
// Program-memory access: table reads, bank selection, reset vector and the IN_APPLICATION_PROGRAMMING register set.
// Assumes a core issuing single-cycle register strobes and a flash macro with word and page strobes.
`include "pmt_defines.vh"

// What this block does
// - Program memory is 16-bit words, 8K to 32K words deep, by variant.
// - Bank pointer bits 6 and 5 select the program-memory bank.
// - After reset, execution begins at program address zero.
// - Table address is the concatenation of high and low table pointers.
// - Table read returns low byte to register, high byte to table_high_byte.
// - Unused high-byte bits read as zero after a table read.
// - table_high_byte is read-only; only table reads change it.
// - Every table read takes two instruction cycles.
// - Page-relative table read uses the current page base address.
// - Programmer moves serial data on one line, clocked by the reset pin; that path lies outside this block.
// - Erase works on pages of 32 or 64 words by variant.
// - Writes program 32 or 64 words at once; reads return one word.
// - Address and data registers are in bank 0, control registers in bank 1.
// - First two control registers are reached only indirectly in bank 1.
// - Mode codes: write 000, erase 001, read 011, unlock 110.
// - Write, read and buffer-clear bits set by software, cleared by hardware.
// - Unlock needs the key within 300 us; procedure enable then clears.
module pmt_core #(
  parameter AW = 15,
  parameter PAGE_WORDS = 64,
  parameter UNLOCK_TICKS = (`PMT_UNLOCK_WINDOW_US * `PMT_LOW_SPEED_INTERNAL_OSCILLATOR_HZ) / 1000000
)(
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire low_speed_internal_oscillator_tick_async,
  input wire [7:0] bank_pointer,
  input wire [AW-1:0] pc_next,
  output wire [AW-1:0] prog_addr,
  input wire tbl_req,
  input wire tbl_page_rel,
  input wire [7:0] tbl_ptr_low,
  input wire [7:0] tbl_ptr_high,
  output reg tbl_busy,
  output reg tbl_done,
  output reg [7:0] tbl_low_data,
  output reg [7:0] table_high_byte,
  output reg [AW-1:0] flash_addr,
  input wire [15:0] flash_rdata,
  output reg [15:0] flash_wdata,
  output reg flash_rd,
  output reg flash_buf_load,
  output reg flash_page_write,
  output reg flash_page_erase,
  output reg flash_buf_clear,
  input wire flash_ack,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_indirect,
  input wire reg_bank,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg chip_reset_req
);
  reg [7:0] fal_q;
  reg [7:0] fah_q;
  reg [7:0] fd_q [0:7];
  reg [7:0] c0_q;
  reg c2_q;
  reg unlocked_q;
  reg [15:0] win_q;
  reg [1:0] tcnt_q;
  reg busy_op_q;
  wire low_speed_internal_oscillator_tick;
  wire [2:0] mode;
  wire sel_c0, sel_c1, sel_c2, sel_fa_lo, sel_fa_hi, sel_fd;
  wire wr_c0;
  wire [AW-1:0] tbl_addr;
  wire key_ok;
  integer i;

  // ----------------------------------------------------------------
  // Slow-oscillator synchroniser and program counter path
  // ----------------------------------------------------------------
  pmt_sync2 u_low_speed_internal_oscillator (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(low_speed_internal_oscillator_tick_async),
    .q(low_speed_internal_oscillator_tick)
  );

  reg low_speed_internal_oscillator_prev_q;
  wire low_speed_internal_oscillator_edge = low_speed_internal_oscillator_tick & ~low_speed_internal_oscillator_prev_q;

  // Bank bits from the bank pointer sit above the 13-bit in-bank address.
  assign prog_addr = (AW > 13) ?
    {bank_pointer[`PMT_BANK_PTR_LO+AW-14:`PMT_BANK_PTR_LO], pc_next[12:0]} : pc_next;

  // Page-relative form keeps the current page and replaces the low byte.
  assign tbl_addr = tbl_page_rel ? {prog_addr[AW-1:8], tbl_ptr_low} :
    {tbl_ptr_high[AW-9:0], tbl_ptr_low};

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign sel_c0 = reg_bank == `PMT_BANK_ONE && reg_indirect && reg_addr == `PMT_ADDR_CTRL_ZERO;
  assign sel_c1 = reg_bank == `PMT_BANK_ONE && reg_indirect && reg_addr == `PMT_ADDR_CTRL_ONE;
  assign sel_c2 = reg_bank == `PMT_BANK_ONE && reg_addr == `PMT_ADDR_CTRL_TWO;
  assign sel_fa_lo = reg_bank == `PMT_BANK_ZERO && reg_addr == `PMT_ADDR_FA_LOW;
  assign sel_fa_hi = reg_bank == `PMT_BANK_ZERO && reg_addr == `PMT_ADDR_FA_HIGH;
  assign sel_fd = reg_bank == `PMT_BANK_ZERO && reg_addr >= `PMT_ADDR_FD_BASE && reg_addr <= `PMT_ADDR_FD_LAST;
  assign wr_c0 = reg_wr && sel_c0;
  assign mode = c0_q[`PMT_C0_MODE_HI:`PMT_C0_MODE_LO];
  assign key_ok = fd_q[2] == `PMT_KEY_D1L && fd_q[3] == `PMT_KEY_D1H && fd_q[4] == `PMT_KEY_D2L &&
    fd_q[5] == `PMT_KEY_D2H && fd_q[6] == `PMT_KEY_D3L && fd_q[7] == `PMT_KEY_D3H;

  always @*
  begin
    reg_rdata = 8'h00;
    if (reg_rd)
    begin
      if (sel_c0)
        reg_rdata = {unlocked_q, c0_q[6:0]};
      else if (sel_c2)
        reg_rdata = {7'h00, c2_q};
      else if (sel_fa_lo)
        reg_rdata = fal_q;
      else if (sel_fa_hi)
        reg_rdata = fah_q;
      else if (sel_fd)
        reg_rdata = fd_q[reg_addr[2:0] - 3'h5];
    end
  end

  // ----------------------------------------------------------------
  // Table read sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tbl_busy <= 1'b0;
      tbl_done <= 1'b0;
      tcnt_q <= 2'h0;
      tbl_low_data <= 8'h00;
      table_high_byte <= 8'h00;
    end
    else if (clk_en)
    begin
      tbl_done <= 1'b0;
      if (!tbl_busy && tbl_req)
      begin
        tbl_busy <= 1'b1;
        tcnt_q <= `PMT_TABLE_CYCLES - 2'h1;
      end
      else if (tbl_busy)
      begin
        if (tcnt_q == 2'h1)
        begin
          tbl_busy <= 1'b0;
          tbl_done <= 1'b1;
          tbl_low_data <= flash_rdata[7:0];
          // Only the table path writes this byte; software writes never reach it.
          table_high_byte <= flash_rdata[15:8];
        end
        tcnt_q <= tcnt_q - 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // IN_APPLICATION_PROGRAMMING registers and control
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      // Serial programming borrows the reset pin as its clock outside this block; reset only restarts.
      fal_q <= 8'h00;
      fah_q <= 8'h00;
      for (i = 0; i < 8; i = i + 1)
        fd_q[i] <= 8'h00;
      c0_q <= 8'h00;
      c2_q <= 1'b0;
      unlocked_q <= 1'b0;
      win_q <= 16'h0000;
      low_speed_internal_oscillator_prev_q <= 1'b0;
      busy_op_q <= 1'b0;
      chip_reset_req <= 1'b0;
      flash_addr <= `PMT_RESET_VECTOR;
      flash_wdata <= 16'h0000;
      flash_rd <= 1'b0;
      flash_buf_load <= 1'b0;
      flash_page_write <= 1'b0;
      flash_page_erase <= 1'b0;
      flash_buf_clear <= 1'b0;
    end
    else if (clk_en)
    begin
      low_speed_internal_oscillator_prev_q <= low_speed_internal_oscillator_tick;
      flash_rd <= 1'b0;
      flash_buf_load <= 1'b0;
      flash_page_write <= 1'b0;
      flash_page_erase <= 1'b0;
      flash_buf_clear <= 1'b0;
      chip_reset_req <= reg_wr && sel_c1 && reg_wdata == `PMT_CHIP_RESET_KEY;
      // A table read points the flash at its word; the word is latched when the read ends.
      if (!tbl_busy && tbl_req)
        flash_addr <= tbl_addr;
      if (reg_wr && sel_fa_lo)
        fal_q <= reg_wdata;
      if (reg_wr && sel_fa_hi)
        fah_q <= reg_wdata & ((8'h01 << (AW - 8)) - 8'h01);
      if (reg_wr && sel_fd)
        fd_q[reg_addr[2:0] - 3'h5] <= reg_wdata;
      if (wr_c0)
      begin
        // Start bits only set from software; a written zero leaves them alone.
        c0_q[6:3] <= reg_wdata[6:3];
        c0_q[`PMT_C0_RDEN] <= reg_wdata[`PMT_C0_RDEN];
        c0_q[`PMT_C0_WRITE] <= c0_q[`PMT_C0_WRITE] | reg_wdata[`PMT_C0_WRITE];
        c0_q[`PMT_C0_READ] <= c0_q[`PMT_C0_READ] | reg_wdata[`PMT_C0_READ];
        if (!reg_wdata[`PMT_C0_CONFIRM])
          unlocked_q <= 1'b0;
        if (reg_wdata[`PMT_C0_PROC_EN] && reg_wdata[6:4] == `PMT_MODE_UNLOCK)
          win_q <= UNLOCK_TICKS[15:0];
      end
      if (reg_wr && sel_c2 && reg_wdata[0])
        c2_q <= 1'b1;
      // Unlock window counts slow-oscillator ticks; success or timeout clears the enable.
      if (c0_q[`PMT_C0_PROC_EN] && mode == `PMT_MODE_UNLOCK && !wr_c0)
      begin
        if (key_ok)
        begin
          unlocked_q <= 1'b1;
          c0_q[`PMT_C0_PROC_EN] <= 1'b0;
        end
        else if (win_q == 16'h0000)
          c0_q[`PMT_C0_PROC_EN] <= 1'b0;
        else if (low_speed_internal_oscillator_edge)
          win_q <= win_q - 16'h0001;
      end
      // Write-mode procedure enable moves the first data pair into the page buffer.
      if (c0_q[`PMT_C0_PROC_EN] && mode == `PMT_MODE_WRITE && unlocked_q && !wr_c0)
      begin
        flash_addr <= {fah_q[AW-9:0], fal_q};
        flash_wdata <= {fd_q[1], fd_q[0]};
        flash_buf_load <= 1'b1;
        c0_q[`PMT_C0_PROC_EN] <= 1'b0;
      end
      if (!busy_op_q && c2_q)
      begin
        flash_buf_clear <= 1'b1;
        busy_op_q <= 1'b1;
      end
      else if (!busy_op_q && c0_q[`PMT_C0_WRITE] && unlocked_q)
      begin
        // Page base: low address bits inside the page are ignored.
        flash_addr <= {fah_q[AW-9:0], fal_q} & ~(PAGE_WORDS[AW-1:0] - {{(AW-1){1'b0}}, 1'b1});
        if (mode == `PMT_MODE_ERASE)
          flash_page_erase <= 1'b1;
        else
          flash_page_write <= 1'b1;
        busy_op_q <= 1'b1;
      end
      else if (!busy_op_q && c0_q[`PMT_C0_READ] && c0_q[`PMT_C0_RDEN] && mode == `PMT_MODE_READ)
      begin
        flash_addr <= {fah_q[AW-9:0], fal_q};
        flash_rd <= 1'b1;
        busy_op_q <= 1'b1;
      end
      else if (busy_op_q && flash_ack)
      begin
        busy_op_q <= 1'b0;
        // A start bit set again by software in the completing cycle survives the clear.
        if (c2_q)
        begin
          if (!(reg_wr && sel_c2 && reg_wdata[0]))
            c2_q <= 1'b0;
        end
        else if (c0_q[`PMT_C0_WRITE])
        begin
          if (!(wr_c0 && reg_wdata[`PMT_C0_WRITE]))
            c0_q[`PMT_C0_WRITE] <= 1'b0;
        end
        else
        begin
          if (!(wr_c0 && reg_wdata[`PMT_C0_READ]))
            c0_q[`PMT_C0_READ] <= 1'b0;
          fd_q[0] <= flash_rdata[7:0];
          fd_q[1] <= flash_rdata[15:8];
        end
      end
    end
  end
endmodule

// ===== verification/pmt_flash_model.sv
// Flash macro stand-in that answers table reads and IN_APPLICATION_PROGRAMMING strobes with an address-derived word.
// Assumes one strobe at a time; the slow input stretches the acknowledge delay.
module pmt_flash_model (
  input wire clk_sys,
  input wire [14:0] flash_addr,
  input wire flash_rd,
  input wire flash_buf_load,
  input wire flash_page_write,
  input wire flash_page_erase,
  input wire flash_buf_clear,
  input wire slow,
  output logic [15:0] flash_rdata,
  output logic flash_ack = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_q = 3'h0;
  assign flash_rdata = {flash_addr[7:0] ^ 8'hA5, flash_addr[14:7]};
  always @(posedge clk_sys)
  begin
    flash_ack <= wait_q == 3'h1;
    if (flash_rd | flash_buf_load | flash_page_write | flash_page_erase | flash_buf_clear)
      wait_q <= slow ? 3'h5 : 3'h1;
    else if (wait_q != 3'h0)
      wait_q <= wait_q - 3'h1;
  end
endmodule

// ===== verification/pmt_core_properties.sv
// Checker for table-read timing, table addressing, bank selection and control register guard.
// Assumes binding to pmt_core with AW of 15.
module pmt_core_properties #(
  parameter AW = 15
)(
  input wire clk_sys,
  input wire rst_n,
  input wire tbl_req,
  input wire tbl_busy,
  input wire tbl_done,
  input wire tbl_page_rel,
  input wire [7:0] tbl_ptr_low,
  input wire [7:0] tbl_ptr_high,
  input wire [7:0] tbl_low_data,
  input wire [7:0] table_high_byte,
  input wire [AW-1:0] flash_addr,
  input wire [15:0] flash_rdata,
  input wire [AW-1:0] prog_addr,
  input wire [AW-1:0] pc_next,
  input wire [7:0] bank_pointer,
  input wire flash_rd,
  input wire reg_rd,
  input wire reg_indirect,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    tbl_req && !tbl_busy;
  endsequence
  sequence s_answer;
    tbl_busy && !tbl_done ##1 tbl_done ##1 !tbl_done;
  endsequence
  a_table_two_cycles: assert property (s_take |=> s_answer)
    else $error("table read did not finish in two cycles");
  a_done_has_cause: assert property (tbl_done |-> $past(tbl_req, 2) && !$past(tbl_busy, 2))
    else $error("table done without a request");
  a_high_byte_hold: assert property (!$stable(table_high_byte) |-> tbl_done)
    else $error("table high byte changed outside a table read");
  a_table_data: assert property (tbl_done |-> {table_high_byte, tbl_low_data} == $past(flash_rdata))
    else $error("table data differs from program word");
  a_table_addr: assert property (s_take ##0 !tbl_page_rel |=>
    flash_addr == {$past(tbl_ptr_high[AW-9:0]), $past(tbl_ptr_low)})
    else $error("table address not formed from both pointers");
  a_page_relative: assert property (s_take ##0 tbl_page_rel |=>
    flash_addr == {$past(prog_addr[AW-1:8]), $past(tbl_ptr_low)})
    else $error("page relative table address wrong");
  a_bank_select: assert property (prog_addr == {bank_pointer[AW-9:5], pc_next[12:0]})
    else $error("program address bank bits wrong");
  a_direct_refused: assert property (reg_rd && !reg_indirect && reg_addr[7:1] == 7'h20 |->
    reg_rdata == 8'h00)
    else $error("control register readable directly");
  a_read_one_word: assert property (flash_rd |=> !flash_rd)
    else $error("read strobe longer than one word");
endmodule

bind pmt_core pmt_core_properties #(.AW(AW)) u_props (.clk_sys(clk_sys), .rst_n(rst_n), .tbl_req(tbl_req),
  .tbl_busy(tbl_busy), .tbl_done(tbl_done), .tbl_page_rel(tbl_page_rel), .tbl_ptr_low(tbl_ptr_low),
  .tbl_ptr_high(tbl_ptr_high), .tbl_low_data(tbl_low_data), .table_high_byte(table_high_byte),
  .flash_addr(flash_addr), .flash_rdata(flash_rdata), .prog_addr(prog_addr), .pc_next(pc_next),
  .bank_pointer(bank_pointer), .flash_rd(flash_rd), .reg_rd(reg_rd), .reg_indirect(reg_indirect),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata));

// ===== verification/tb_top.sv
// Self-checking bench for pmt_core: random table reads, register map, unlock, erase and read.
// Assumes the flash model as far side and a shortened unlock window of three slow ticks.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_n = 0, clk_en = 1, tbl_req = 0, tbl_page_rel = 0, slow = 0, ok;
  logic reg_wr = 0, reg_rd = 0, reg_ind = 0, reg_bank = 0, busy, done, f_rd, f_ld, f_wr, f_er, f_cl, ack, crr;
  logic [7:0] bp = 0, ptl = 0, pth = 0, reg_addr = 0, reg_wdata = 0, reg_rdata, tlow, thigh, rv;
  logic [14:0] pc = 0, prog_addr, faddr, ea;
  logic [15:0] read_start_bit, fwd;
  logic [5:0] lcnt = 0;
  logic [31:0] seed = 32'h57CE;
  logic [7:0] key [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
  int miscompares = 0, total_checks = 0, ers = 0, rds = 0, r0;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    lcnt <= lcnt + 6'h01;
    if (f_er === 1'b1 || f_wr === 1'b1) ea <= faddr;
    ers <= ers + (f_er === 1'b1);
    rds <= rds + (f_rd === 1'b1);
  end
  pmt_core #(.UNLOCK_TICKS(3)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .low_speed_internal_oscillator_tick_async(lcnt[4]),
    .bank_pointer(bp), .pc_next(pc), .prog_addr(prog_addr), .tbl_req(tbl_req), .tbl_page_rel(tbl_page_rel),
    .tbl_ptr_low(ptl), .tbl_ptr_high(pth), .tbl_busy(busy), .tbl_done(done), .tbl_low_data(tlow),
    .table_high_byte(thigh), .flash_addr(faddr), .flash_rdata(read_start_bit), .flash_wdata(fwd), .flash_rd(f_rd),
    .flash_buf_load(f_ld), .flash_page_write(f_wr), .flash_page_erase(f_er), .flash_buf_clear(f_cl),
    .flash_ack(ack), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_indirect(reg_ind), .reg_bank(reg_bank),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .chip_reset_req(crr));
  pmt_flash_model fm (.clk_sys(clk_sys), .flash_addr(faddr), .flash_rd(f_rd), .flash_buf_load(f_ld),
    .flash_page_write(f_wr), .flash_page_erase(f_er), .flash_buf_clear(f_cl), .slow(slow),
    .flash_rdata(read_start_bit), .flash_ack(ack));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] word(input logic [14:0] a);
    word = {a[7:0] ^ 8'hA5, a[14:7]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic ind, input logic bk, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) {reg_wr, reg_rd, reg_ind, reg_bank, reg_addr, reg_wdata} <= {wr, ~wr, ind, bk, a, d};
    @(negedge clk_sys) rv = reg_rdata;
    @(posedge clk_sys) {reg_wr, reg_rd} <= 2'b00;
  endtask
  task automatic wack();
    ok = 0;
    repeat (20) @(negedge clk_sys) if (ack === 1'b1) ok = 1;
  endtask
  // A second request is held into the busy cycle and must be ignored.
  task automatic tread(input logic pr);
    logic [14:0] a;
    @(posedge clk_sys) {tbl_req, tbl_page_rel} <= {1'b1, pr};
    a = pr ? {bp[6:5], pc[12:8], ptl} : {pth[6:0], ptl};
    @(posedge clk_sys) tbl_req <= 1'b1;
    @(posedge clk_sys) tbl_req <= 1'b0;
    @(negedge clk_sys) chk({done, thigh, tlow}, {1'b1, word(a)});
  endtask
  task automatic test_done();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    test_done();
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys) chk({thigh, prog_addr}, 0);
    for (int i = 0; i < 13; i++)
    begin
      acc(0, 1, i < 3, 8'(8'h40 + i), 0);
      chk(rv, 0);
    end
    acc(1, 1, 1, 8'h41, 8'h55);
    @(negedge clk_sys) chk(crr, 1);
    acc(1, 0, 1, 8'h41, 8'h55);
    @(negedge clk_sys) chk(crr, 0);
    @(posedge clk_sys) {pth, ptl} <= 16'h7FFF;
    tread(0);
    tread(1);
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      @(posedge clk_sys) {bp, pc, ptl, pth} <= {seed[7:0], ~seed[14:0], seed[31:24], seed[23:16]};
      tread(seed[3]);
      @(negedge clk_sys) chk(prog_addr, {bp[6:5], pc[12:0]});
    end
    acc(1, 1, 1, 8'h40, 8'h68);
    for (int i = 0; i < 6; i++) acc(1, 0, 0, 8'(8'h47 + i), key[i]);
    acc(1, 0, 1, 8'h40, 8'h00);
    acc(0, 0, 1, 8'h40, 0);
    chk(rv, 0);
    acc(0, 1, 1, 8'h40, 0);
    chk(rv, 8'hE0);
    acc(1, 1, 1, 8'h42, 8'h01); // buffer cleared first
    wack();
    acc(0, 1, 1, 8'h42, 0);
    chk({ok, rv}, 9'h100);
    acc(1, 0, 0, 8'h43, 8'h5B);
    acc(1, 0, 0, 8'h44, 8'h01);
    acc(1, 1, 1, 8'h40, 8'h94);
    wack();
    acc(0, 1, 1, 8'h40, 0);
    chk({ok, rv, ers[7:0], ea[14:6]}, {1'b1, 8'h90, 8'h01, 9'h005});
    clk_en <= 1'b0;
    acc(1, 0, 0, 8'h43, 8'hAA);
    clk_en <= 1'b1;
    acc(0, 0, 0, 8'h43, 0);
    chk(rv, 8'h5B);
    slow <= 1'b1;
    r0 = rds;
    acc(1, 1, 1, 8'h40, 8'hB3);
    wack();
    acc(0, 0, 0, 8'h45, 0);
    chk({ok, rv}, {1'b1, 8'(word(15'h015B))});
    chk(rds - r0, 1);
    acc(0, 0, 0, 8'h46, 0);
    chk(rv, word(15'h015B) >> 8);
    acc(0, 1, 1, 8'h40, 0);
    chk(rv, 8'hB2);
    acc(1, 1, 1, 8'h42, 8'h01);
    wack();
    acc(1, 0, 0, 8'h43, 8'h9B);
    acc(1, 1, 1, 8'h40, 8'h88);
    @(posedge clk_sys);
    @(negedge clk_sys) chk({f_ld, fwd}, {1'b1, word(15'h015B)});
    acc(1, 1, 1, 8'h40, 8'h84);
    wack();
    acc(0, 1, 1, 8'h40, 0);
    chk({ok, rv, ers[7:0], ea[14:6]}, {1'b1, 8'h80, 8'h01, 9'h006});
    acc(1, 1, 1, 8'h40, 8'h00);
    acc(1, 0, 0, 8'h47, 8'hFF);
    acc(1, 1, 1, 8'h40, 8'h68);
    repeat (200) @(posedge clk_sys);
    for (int i = 0; i < 6; i++) acc(1, 0, 0, 8'(8'h47 + i), key[i]);
    acc(0, 1, 1, 8'h40, 0);
    chk(rv & 8'h88, 0);
    acc(1, 1, 1, 8'h40, 8'h14);
    wack();
    chk(ok, 0);
    test_done();
  end
endmodule
